// File: rtl/dpr_pkg.sv
// Package of addresses, reset values and constants for the dual-port register map
package dpr_pkg;

  // Special function register addresses
  localparam logic [7:0] SFR_BRK_LO      = 8'hD9;
  localparam logic [7:0] SFR_BRK_HI      = 8'hDA;
  localparam logic [7:0] SFR_SYNTH3      = 8'hDB;
  localparam logic [7:0] SFR_HW_MODEL_REVISION       = 8'hDC;
  localparam logic [7:0] SFR_SYNTH4      = 8'hDD;
  localparam logic [7:0] SFR_OSC_HI      = 8'hDE;
  localparam logic [7:0] SFR_OSC_LO      = 8'hDF;
  localparam logic [7:0] SFR_ARITH       = 8'hE0;
  localparam logic [7:0] SFR_FLASH_RD    = 8'hE1;
  localparam logic [7:0] SFR_STACK_LO    = 8'hE3;
  localparam logic [7:0] SFR_STACK_HI    = 8'hE4;
  localparam logic [7:0] SFR_GATE_KILL   = 8'hE5;
  localparam logic [7:0] SFR_PORT5       = 8'hE7;
  localparam logic [7:0] SFR_IE2         = 8'hE8;
  localparam logic [7:0] SFR_SHARED0     = 8'hE9;
  localparam logic [7:0] SFR_SHARED3     = 8'hEC;
  localparam logic [7:0] SFR_OPERAND     = 8'hF0;
  localparam logic [7:0] SFR_IP2         = 8'hF8;

  // Reset values
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam logic [7:0] RST_SYNTH4      = 8'h08;
  localparam logic [7:0] RST_SYNTH3      = 8'h00;
  localparam logic [7:0] RST_OSC         = 8'h00;

  // Peripheral window in shared data memory
  localparam logic [15:0] WIN_BASE       = 16'hF100;
  localparam logic [15:0] WIN_LAST       = 16'hF7FF;
  localparam logic [11:0] ENG_BASE       = 12'hE80;
  localparam int          WIN_SCALE      = 2;

  // Baud divisor register
  localparam logic [11:0] ENG_BAUD       = 12'hE8C;
  localparam logic [15:0] MCU_BAUD_LO    = 16'hF118;
  localparam logic [15:0] MCU_BAUD_HI    = 16'hF119;
  localparam logic [15:0] RST_BAUD       = 16'h0000;

  // Peripheral register slots: 4 bytes each in the micro view
  localparam int          SLOT_BYTES     = 4;
  localparam int          NUM_SLOTS      = 448;

endpackage : dpr_pkg

// File: rtl/dpr_sync.sv
// Two-stage reset release synchroniser
`timescale 1ns/1ns
`default_nettype none
module dpr_sync (
  // Clock and raw reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Synchronised reset
  output var  logic rst_n
);
  logic stage;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      stage <= 1'b1;
      rst_n <= stage;
    end
  end
endmodule : dpr_sync
`default_nettype wire

// File: rtl/dpr_regs.sv
// Dual-view register bank shared by the 8-bit micro and the 16-bit engine
//
// Functional notes
// - Peripheral registers sit in shared memory at 0xF100 to 0xF7FF.
// - Micro can read and write every peripheral register; engine reaches only 0xF100 to 0xF3FF.
// - Each peripheral register is 8 to 32 bits wide, chosen per register.
// - Micro bus sees multi-byte registers little endian, low byte lowest address.
// - Engine sees registers over 16 bits as low word at lower address.
// - Micro sees wide registers as byte pieces, engine as 16-bit words.
// - Micro address equals (engine address minus 0xE80) times 2 plus 0xF100.
// - Hardware model and revision at DC is fixed and ignores writes.
// - Engine stack registers E3 and E4 are read-only and reset to 00.
// - Clock synth byte DD resets to 08, present only in flash variant.
// - Baud divisor at engine E8C shows as micro bytes F118 and F119.
`timescale 1ns/1ns
`default_nettype none
module dpr_regs
  import dpr_pkg::*;
#(
  parameter logic [7:0] HW_ID         = 8'h5A, // Arbitrary identification value
  parameter bit         FLASH_VARIANT = 1'b1
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Micro special function register port
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output var  logic [7:0]  sfr_rdata,
  // Micro external data port
  input  wire logic [15:0] xd_addr,
  input  wire logic        xd_wr,
  input  wire logic        xd_rd,
  input  wire logic [7:0]  xd_wdata,
  output var  logic [7:0]  xd_rdata,
  output var  logic        xd_hit,
  // Engine word port
  input  wire logic [11:0] eng_addr,
  input  wire logic        eng_wr,
  input  wire logic        eng_rd,
  input  wire logic [15:0] eng_wdata,
  output var  logic [15:0] eng_rdata,
  output var  logic        eng_hit,
  // Engine side state
  input  wire logic [15:0] eng_stack,
  // Control outputs
  output var  logic [7:0]  gate_kill_cfg,
  output var  logic [15:0] uart_baud_divisor
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_n;

  dpr_sync u_sync (
    .clk    (clk),
    .arst_n (arst_n),
    .rst_n  (rst_n)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State
  typedef enum logic [1:0] {
    DPR_IDLE = 2'b00,
    DPR_HELD = 2'b01
  } dpr_arb_t;

  // Registered outputs other than uart_baud_divisor live in the state; every output comes from a flop
  typedef struct packed {
    logic [7:0]  brk_lo;
    logic [7:0]  brk_hi;
    logic [7:0]  synth3;
    logic [7:0]  synth4;
    logic [7:0]  osc_hi;
    logic [7:0]  osc_lo;
    logic [7:0]  arith;
    logic [7:0]  gate_kill;
    logic [7:0]  port5;
    logic [7:0]  ie2;
    logic [31:0] shared;
    logic [7:0]  operand;
    logic [7:0]  ip2;
    logic [15:0] stack;
    logic [7:0]  sfr_rdata;
    logic [7:0]  xd_rdata;
    logic        xd_hit;
    logic [15:0] eng_rdata;
    logic        eng_hit;
    dpr_arb_t    arb;
    logic        held_wr;
    logic        held_rd;
    logic [11:0] held_addr;
    logic [15:0] held_wdata;
  } dpr_state_t;

  dpr_state_t cur;
  dpr_state_t next_cur;

  // Peripheral register storage, one byte per micro address, 4 bytes per 32-bit slot; 8 to 32 bit registers fit
  // Reset clears the whole window: wide reset fan-out, but reads never see unknowns
  logic [7:0] mem_b [NUM_SLOTS*SLOT_BYTES];

  ////////////////////////////////////////////////////////////////////////////
  // Address translation
  // Below 0xE80 the subtraction wraps, so eng_ok checks the lower bound too
  function automatic logic [15:0] eng_to_mcu(input logic [11:0] a);
    eng_to_mcu = 16'((a - ENG_BASE) * WIN_SCALE) + WIN_BASE;
  endfunction : eng_to_mcu

  function automatic logic in_window(input logic [15:0] a);
    in_window = (a >= WIN_BASE) && (a <= WIN_LAST);
  endfunction : in_window

  function automatic logic is_shared(input logic [7:0] a);
    is_shared = (a >= SFR_SHARED0) && (a <= SFR_SHARED3);
  endfunction : is_shared

  logic [15:0] eng_mcu;
  logic [10:0] xd_off;
  logic [10:0] eng_off;
  logic        eng_ok;
  logic        xd_ok;
  logic        clash;
  logic [10:0] held_off;
  logic [15:0] held_mcu;

  always_comb begin
    eng_mcu = eng_to_mcu(eng_addr);
    eng_ok  = (eng_addr >= ENG_BASE) && in_window(eng_mcu);
    eng_off = eng_mcu[10:0] - WIN_BASE[10:0];
    xd_ok   = in_window(xd_addr);
    xd_off  = xd_addr[10:0] - WIN_BASE[10:0];
    // Both masters hitting one 32-bit slot in one cycle
    clash   = xd_ok && eng_ok && (xd_rd || xd_wr) && (eng_rd || eng_wr)
              && (xd_off[10:2] == eng_off[10:2]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    next_cur           = cur;
    next_cur.stack     = eng_stack;
    next_cur.xd_hit    = 1'b0;
    next_cur.eng_hit   = 1'b0;

    if (sfr_wr) begin
      unique case (sfr_addr)
        SFR_BRK_LO:    next_cur.brk_lo    = sfr_wdata;
        SFR_BRK_HI:    next_cur.brk_hi    = sfr_wdata;
        SFR_SYNTH3:    next_cur.synth3    = sfr_wdata;
        SFR_SYNTH4:    if (FLASH_VARIANT) next_cur.synth4 = sfr_wdata;
        SFR_OSC_HI:    next_cur.osc_hi    = sfr_wdata;
        SFR_OSC_LO:    next_cur.osc_lo    = sfr_wdata;
        SFR_ARITH:     next_cur.arith     = sfr_wdata;
        SFR_GATE_KILL: next_cur.gate_kill = sfr_wdata;
        SFR_PORT5:     next_cur.port5     = sfr_wdata;
        SFR_IE2:       next_cur.ie2       = sfr_wdata;
        SFR_OPERAND:   next_cur.operand   = sfr_wdata;
        SFR_IP2:       next_cur.ip2       = sfr_wdata;
        default: begin
          // Coherent data bytes; identity and stack bytes ignore writes
          if (is_shared(sfr_addr)) begin
            next_cur.shared[8*(sfr_addr-SFR_SHARED0) +: 8] = sfr_wdata;
          end
        end
      endcase
    end

    // Unmapped addresses read back as zero
    if (sfr_rd) begin
      case (sfr_addr)
        SFR_BRK_LO:    next_cur.sfr_rdata = cur.brk_lo;
        SFR_BRK_HI:    next_cur.sfr_rdata = cur.brk_hi;
        SFR_SYNTH3:    next_cur.sfr_rdata = cur.synth3;
        SFR_HW_MODEL_REVISION:     next_cur.sfr_rdata = HW_ID;
        SFR_SYNTH4:    next_cur.sfr_rdata = FLASH_VARIANT ? cur.synth4 : RST_ZERO;
        SFR_OSC_HI:    next_cur.sfr_rdata = cur.osc_hi;
        SFR_OSC_LO:    next_cur.sfr_rdata = cur.osc_lo;
        SFR_ARITH:     next_cur.sfr_rdata = cur.arith;
        SFR_FLASH_RD:  next_cur.sfr_rdata = RST_ZERO;
        SFR_STACK_LO:  next_cur.sfr_rdata = cur.stack[7:0];
        SFR_STACK_HI:  next_cur.sfr_rdata = cur.stack[15:8];
        SFR_GATE_KILL: next_cur.sfr_rdata = cur.gate_kill;
        SFR_PORT5:     next_cur.sfr_rdata = cur.port5;
        SFR_IE2:       next_cur.sfr_rdata = cur.ie2;
        SFR_OPERAND:   next_cur.sfr_rdata = cur.operand;
        SFR_IP2:       next_cur.sfr_rdata = cur.ip2;
        default: begin
          if (is_shared(sfr_addr)) begin
            next_cur.sfr_rdata = cur.shared[8*(sfr_addr-SFR_SHARED0) +: 8];
          end else begin
            next_cur.sfr_rdata = RST_ZERO;
          end
        end
      endcase
    end

    // Micro window read; engine access deferred on a clash
    if (xd_rd && xd_ok) begin
      next_cur.xd_rdata = mem_b[xd_off];
      next_cur.xd_hit   = 1'b1;
    end
    if (xd_wr && xd_ok) begin
      next_cur.xd_hit = 1'b1;
    end

    case (cur.arb)
      DPR_IDLE: begin
        if (clash && eng_ok) begin
          next_cur.arb        = DPR_HELD;
          next_cur.held_wr    = eng_wr;
          next_cur.held_rd    = eng_rd;
          next_cur.held_addr  = eng_addr;
          next_cur.held_wdata = eng_wdata;
        end else if (eng_ok && eng_rd) begin
          next_cur.eng_rdata = {mem_b[eng_off+11'd1], mem_b[eng_off]};
          next_cur.eng_hit   = 1'b1;
        end else if (eng_ok && eng_wr) begin
          next_cur.eng_hit = 1'b1;
        end
      end
      DPR_HELD: begin
        // A new engine request in this cycle is not taken; callers wait for eng_hit
        next_cur.arb     = DPR_IDLE;
        next_cur.eng_hit = 1'b1;
        if (cur.held_rd) begin
          next_cur.eng_rdata = {mem_b[held_off+11'd1], mem_b[held_off]};
        end
      end
      default: next_cur.arb = DPR_IDLE;
    endcase
  end

  always_comb begin
    held_mcu = eng_to_mcu(cur.held_addr);
    held_off = held_mcu[10:0] - WIN_BASE[10:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cur           <= '0;
      cur.synth4    <= RST_SYNTH4;
      cur.arb       <= DPR_IDLE;
    end else begin
      cur <= next_cur;
    end
  end

  // Shared window storage: micro writes first, held engine write next cycle
  // A held engine write lands after the clashing micro byte, so its word stands whole
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_SLOTS*SLOT_BYTES; i++) begin
        mem_b[i] <= RST_ZERO;
      end
    end else begin
      if (xd_wr && xd_ok) begin
        mem_b[xd_off] <= xd_wdata;
      end
      if (cur.arb == DPR_IDLE && eng_ok && eng_wr && !clash) begin
        mem_b[eng_off]        <= eng_wdata[7:0];
        mem_b[eng_off+11'd1]  <= eng_wdata[15:8];
      end else if (cur.arb == DPR_HELD && cur.held_wr) begin
        mem_b[held_off]       <= cur.held_wdata[7:0];
        mem_b[held_off+11'd1] <= cur.held_wdata[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  always_comb begin
    sfr_rdata         = cur.sfr_rdata;
    xd_rdata          = cur.xd_rdata;
    xd_hit            = cur.xd_hit;
    eng_rdata         = cur.eng_rdata;
    eng_hit           = cur.eng_hit;
    gate_kill_cfg     = cur.gate_kill;
    uart_baud_divisor = {mem_b[MCU_BAUD_HI[10:0]-WIN_BASE[10:0]],
                         mem_b[MCU_BAUD_LO[10:0]-WIN_BASE[10:0]]};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_hw_model_revision_fixed: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_rd && sfr_addr == SFR_HW_MODEL_REVISION |=> sfr_rdata == HW_ID)
    else $error("identity byte not fixed");
  chk_stack_ro: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_rd && sfr_addr == SFR_STACK_LO |=> sfr_rdata == 8'($past(eng_stack, 2)))
    else $error("stack byte mismatch");
  chk_clash_defer: assert property (@(posedge clk) disable iff (!rst_n)
    clash && cur.arb == DPR_IDLE |=> cur.arb == DPR_HELD ##1 eng_hit)
    else $error("clash not serialised");
  chk_eng_done: assert property (@(posedge clk) disable iff (!rst_n)
    eng_ok && eng_rd && cur.arb == DPR_IDLE |-> ##[1:2] eng_hit)
    else $error("engine access lost");
  chk_xd_hit: assert property (@(posedge clk) disable iff (!rst_n)
    (xd_rd || xd_wr) |=> xd_hit == $past(xd_ok))
    else $error("window decode wrong");
  chk_xd_write: assert property (@(posedge clk) disable iff (!rst_n)
    xd_wr && xd_ok ##1 xd_rd && xd_ok && $stable(xd_addr) && !xd_wr
      |=> xd_rdata == $past(xd_wdata, 2))
    else $error("byte write lost");
  chk_shared_rw: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_wr && sfr_addr == SFR_SHARED0 ##1 sfr_rd && sfr_addr == SFR_SHARED0 && !sfr_wr
      |=> sfr_rdata == $past(sfr_wdata, 2))
    else $error("shared byte lost");
  chk_gate_cfg: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_wr && sfr_addr == SFR_GATE_KILL |=> gate_kill_cfg == $past(sfr_wdata))
    else $error("gate kill config lost");
  chk_stack_hi: assert property (@(posedge clk) disable iff (!rst_n)
    sfr_rd && sfr_addr == SFR_STACK_HI |=> sfr_rdata == 8'($past(eng_stack, 2) >> 8))
    else $error("stack high byte mismatch");
  chk_xlate_addr: assert property (@(posedge clk) disable iff (!rst_n)
    eng_ok |-> eng_mcu == WIN_BASE + 16'({eng_addr - ENG_BASE, 1'b0}))
    else $error("engine address translation wrong");
  chk_baud_low: assert property (@(posedge clk) disable iff (!rst_n)
    xd_wr && xd_addr == MCU_BAUD_LO && cur.arb == DPR_IDLE |=> uart_baud_divisor[7:0] == $past(xd_wdata))
    else $error("baud low byte lost");
  chk_baud_high: assert property (@(posedge clk) disable iff (!rst_n)
    xd_wr && xd_addr == MCU_BAUD_HI && cur.arb == DPR_IDLE |=> uart_baud_divisor[15:8] == $past(xd_wdata))
    else $error("baud high byte lost");
  chk_eng_baud: assert property (@(posedge clk) disable iff (!rst_n)
    eng_wr && eng_addr == ENG_BAUD && !clash && cur.arb == DPR_IDLE |=> uart_baud_divisor == $past(eng_wdata))
    else $error("engine word write lost");
  chk_held_once: assert property (@(posedge clk) disable iff (!rst_n)
    cur.arb == DPR_HELD |=> cur.arb == DPR_IDLE)
    else $error("held access not released");
  cov_clash: cover property (@(posedge clk) disable iff (!rst_n) clash);
  cov_shared_wr: cover property (@(posedge clk) disable iff (!rst_n) sfr_wr && is_shared(sfr_addr));
  cov_stack_rd: cover property (@(posedge clk) disable iff (!rst_n) sfr_rd && sfr_addr == SFR_STACK_LO);
  cov_baud: cover property (@(posedge clk) disable iff (!rst_n) xd_wr && xd_addr == MCU_BAUD_HI);
  cov_eng_rd: cover property (@(posedge clk) disable iff (!rst_n) eng_rd && eng_ok);

endmodule : dpr_regs
`default_nettype wire

// File: tb/dpr_eng_model.sv
// Engine side model: holds the sequencer stack value shown to the micro
`timescale 1ns/1ns
`default_nettype none
module dpr_eng_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Stack update from the bench
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  // Stack value to the block
  output var  logic [15:0] eng_stack
);
  // Stack only moves on request so the micro sees a stable value between pushes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      eng_stack <= 16'h0000;
    end else if (load) begin
      eng_stack <= load_val;
    end
  end
endmodule : dpr_eng_model
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking testbench for the dual-view register bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import dpr_pkg::*;
  logic        clk, arst_n, sfr_wr, sfr_rd, xd_wr, xd_rd, eng_wr, eng_rd, xd_hit, eng_hit, ld;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, xd_wdata, xd_rdata, gate_kill_cfg;
  logic [15:0] xd_addr, eng_wdata, eng_rdata, eng_stack, uart_baud_divisor, ld_val;
  logic [11:0] eng_addr;
  int          err_total, total_checks, cyc;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  dpr_regs dpr_regs_inst (.clk(clk), .arst_n(arst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .xd_addr(xd_addr), .xd_wr(xd_wr), .xd_rd(xd_rd),
    .xd_wdata(xd_wdata), .xd_rdata(xd_rdata), .xd_hit(xd_hit), .eng_addr(eng_addr), .eng_wr(eng_wr),
    .eng_rd(eng_rd), .eng_wdata(eng_wdata), .eng_rdata(eng_rdata), .eng_hit(eng_hit), .eng_stack(eng_stack),
    .gate_kill_cfg(gate_kill_cfg), .uart_baud_divisor(uart_baud_divisor));
  dpr_eng_model dpr_eng_model_inst (.clk(clk), .arst_n(arst_n), .load(ld), .load_val(ld_val),
    .eng_stack(eng_stack));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  task automatic sfr_op(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a; sfr_wr <= w; sfr_rd <= !w; sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 1'b0; sfr_rd <= 1'b0;
    #1;
  endtask : sfr_op
  task automatic xd_op(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    xd_addr <= a; xd_wr <= w; xd_rd <= !w; xd_wdata <= d;
    @(posedge clk);
    xd_wr <= 1'b0; xd_rd <= 1'b0;
    #1;
  endtask : xd_op
  // Bounded wait for the engine handshake; cyc returns the latency seen
  task automatic eng_wait;
    @(posedge clk);
    eng_wr <= 1'b0; eng_rd <= 1'b0; xd_wr <= 1'b0;
    #1;
    cyc = 1;
    while (eng_hit !== 1'b1 && cyc < 4) begin
      @(posedge clk);
      #1;
      cyc++;
    end
    if (eng_hit !== 1'b1) begin
      err_total++;
      $display("[ERR] engine handshake timed out");
      final_report();
    end
  endtask : eng_wait
  task automatic eng_op(input logic [11:0] a, input logic w, input logic [15:0] d);
    @(posedge clk);
    eng_addr <= a; eng_wr <= w; eng_rd <= !w; eng_wdata <= d;
    eng_wait();
  endtask : eng_op
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [7:0] a[8] = '{SFR_SYNTH4, SFR_STACK_LO, SFR_STACK_HI, 8'hE9, 8'hEA, 8'hEB, 8'hEC, SFR_GATE_KILL};
    for (int i = 0; i < 8; i++) begin
      sfr_op(a[i], 1'b0, 8'h00);
      chk("sfr reset", {8'h00, sfr_rdata}, (i == 0) ? 16'h0008 : 16'h0000);
    end
    chk("baud reset", uart_baud_divisor, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_sfr;
    for (int i = 0; i < 4; i++) sfr_op(8'hE9 + 8'(i), 1'b1, 8'hA0 + 8'(i));
    for (int i = 0; i < 4; i++) begin
      sfr_op(8'hE9 + 8'(i), 1'b0, 8'h00);
      chk("shared data", {8'h00, sfr_rdata}, 16'h00A0 + 16'(i));
    end
    // Write then read back in the very next cycle
    @(posedge clk);
    sfr_addr <= SFR_SHARED0; sfr_wr <= 1'b1; sfr_wdata <= 8'h5C;
    @(posedge clk);
    sfr_wr <= 1'b0; sfr_rd <= 1'b1;
    @(posedge clk);
    sfr_rd <= 1'b0;
    #1;
    chk("shared b2b", {8'h00, sfr_rdata}, 16'h005C);
    sfr_op(SFR_HW_MODEL_REVISION, 1'b1, 8'h00);
    sfr_op(SFR_HW_MODEL_REVISION, 1'b0, 8'h00);
    chk("hw id", {8'h00, sfr_rdata}, 16'h005A);
    sfr_op(SFR_STACK_HI, 1'b1, 8'hFF);
    sfr_op(SFR_STACK_HI, 1'b0, 8'h00);
    chk("stack ro", {8'h00, sfr_rdata}, 16'h0000);
    sfr_op(SFR_GATE_KILL, 1'b1, 8'h3C);
    chk("gate kill", {8'h00, gate_kill_cfg}, 16'h003C);
    $display("test sfr done");
  endtask : t_sfr
  task automatic t_window;
    logic [15:0] a[4] = '{16'hF0FF, 16'hF100, 16'hF7FF, 16'hF800};
    for (int i = 0; i < 4; i++) begin
      xd_op(a[i], 1'b0, 8'h00);
      chk("window hit", {15'h0000, xd_hit}, (i == 1 || i == 2) ? 16'h0001 : 16'h0000);
    end
    $display("test window done");
  endtask : t_window
  task automatic t_baud;
    xd_op(MCU_BAUD_LO, 1'b1, 8'h34);
    chk("xd hit", {15'h0000, xd_hit}, 16'h0001);
    // Byte write then read back in the very next cycle
    @(posedge clk);
    xd_addr <= MCU_BAUD_LO; xd_wr <= 1'b1; xd_wdata <= 8'h34;
    @(posedge clk);
    xd_wr <= 1'b0; xd_rd <= 1'b1;
    @(posedge clk);
    xd_rd <= 1'b0;
    #1;
    chk("xd readback", {8'h00, xd_rdata}, 16'h0034);
    xd_op(MCU_BAUD_HI, 1'b1, 8'h12);
    eng_op(ENG_BAUD, 1'b0, 16'h0000);
    chk("eng baud", eng_rdata, 16'h1234);
    chk("baud out", uart_baud_divisor, 16'h1234);
    eng_op(ENG_BAUD, 1'b1, 16'h5678);
    chk("eng baud wr", uart_baud_divisor, 16'h5678);
    xd_op(MCU_BAUD_HI, 1'b0, 8'h00);
    chk("baud hi byte", {8'h00, xd_rdata}, 16'h0056);
    $display("test baud done");
  endtask : t_baud
  task automatic t_translate;
    logic [11:0] w[3] = '{12'hE81, 12'hE82, 12'hFFF};
    for (int i = 0; i < 3; i++) begin
      eng_op(w[i], 1'b1, 16'hBE00 + 16'(i));
      xd_op(WIN_BASE + 16'((w[i] - ENG_BASE) * 2), 1'b0, 8'h00);
      chk("xlate lo", {8'h00, xd_rdata}, 16'h0000 + 16'(i));
      xd_op(WIN_BASE + 16'((w[i] - ENG_BASE) * 2) + 16'h0001, 1'b0, 8'h00);
      chk("xlate hi", {8'h00, xd_rdata}, 16'h00BE);
    end
    $display("test translate done");
  endtask : t_translate
  task automatic t_stack;
    @(posedge clk);
    ld <= 1'b1; ld_val <= 16'hA55A;
    @(posedge clk);
    ld <= 1'b0;
    sfr_op(SFR_STACK_LO, 1'b0, 8'h00);
    chk("stack lo", {8'h00, sfr_rdata}, 16'h005A);
    sfr_op(SFR_STACK_HI, 1'b0, 8'h00);
    chk("stack hi", {8'h00, sfr_rdata}, 16'h00A5);
    $display("test stack done");
  endtask : t_stack
  task automatic t_clash;
    @(posedge clk);
    xd_addr <= MCU_BAUD_LO; xd_wr <= 1'b1; xd_wdata <= 8'h77;
    eng_addr <= ENG_BAUD; eng_wr <= 1'b1; eng_wdata <= 16'hC3D4;
    eng_wait();
    chk("clash wait", 16'(cyc), 16'h0002);
    chk("clash word", uart_baud_divisor, 16'hC3D4);
    $display("test clash done");
  endtask : t_clash
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0; sfr_addr = 8'h00; sfr_wr = 1'b0; sfr_rd = 1'b0; sfr_wdata = 8'h00; ld = 1'b0;
    xd_addr = 16'h0000; xd_wr = 1'b0; xd_rd = 1'b0; xd_wdata = 8'h00; ld_val = 16'h0000;
    eng_addr = 12'h000; eng_wr = 1'b0; eng_rd = 1'b0; eng_wdata = 16'h0000;
    err_total = 0; total_checks = 0;
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_sfr();
    t_window();
    t_baud();
    t_translate();
    t_stack();
    t_clash();
    final_report();
  end
endmodule : tb_top
`default_nettype wire
